/* hdl/barcode_frame_receiver.sv */
/*
 * Barcode frame receiver: serial character receiver, frame checker,
 * prefix insertion, program name match and annotation hand-off, with an
 * AXI4-Lite register slave. Assumes firmware owns storage and the log file,
 * and that rxd idles high and is synchronous to aclk.
 */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
// Operation
// [R01] Serial 9600 baud, 7 data, even, 1 stop
// [R02] Frames open 0x02, close 0x03
// [R03] Scanner adds no other framing characters
// [R04] At most sixteen data characters per frame
// [R05] Two modes, enabling one disables other
// [R06] Name match loads program, confirm starts
// [R07] Unmatched scan in start mode discarded
// [R08] Annotation mode logs scan as event
// [R09] Up to sixteen prefix characters prepended
// [R10] Ignore scans while running, downloading, backing up
// [R11] Backup due during pending confirm skipped
// [R12] Scanner spaces scans three seconds apart
// [R13] Every good scan shown in test registers; scans sent while a confirm is pending are not received or shown
// [R14] Bad parity, stop, length, missing end discarded
`timescale 1ns/100ps
module barcode_frame_receiver
    import barcode_pkg::*;
#(
    parameter int unsigned BIT_PERIOD = BIT_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rxd,
    input  wire logic        program_running,
    input  wire logic        remote_download,
    input  wire logic        backup_active,
    input  wire logic        backup_due,
    output logic             program_load,
    output logic             program_start,
    output logic [1:0]       program_index,
    output logic             log_event,
    output logic [5:0]       log_len,
    output logic             backup_go,
    output logic             backup_skip
);
    // =========================================================================
    // storage
    logic [6:0]   prefix [MAX_CHARS];
    logic [4:0]   prefix_len;
    logic [6:0]   scan   [MAX_CHARS];
    logic [4:0]   scan_len;
    logic [6:0]   test   [MAX_CHARS];
    logic [4:0]   test_len;
    logic [6:0]   names  [NAME_COUNT][MAX_CHARS];
    logic [4:0]   name_len [NAME_COUNT];
    logic         mode_start;
    logic         mode_annot;
    logic [7:0]   drop_count;
    logic [7:0]   scan_count;
    frame_state_t state;
    rx_char_t     rx;
    logic         frame_bad;

    // character of prefix followed by scan at combined position
    function automatic logic [6:0] joined_char(input logic [5:0] pos);
        logic [5:0] k;
        k = pos - {1'b0, prefix_len};
        if (pos < {1'b0, prefix_len}) begin
            return prefix[pos[3:0]];
        end
        return scan[k[3:0]];
    endfunction

    // =========================================================================
    // serial character receiver
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [3:0]           bit_num;
    logic                 rx_busy;
    logic [7:0]           shreg;

    // [R01] sample mid-bit, check parity
    always_ff @(posedge aclk) begin
        rx.valid <= 1'b0;
        if (!aresetn) begin
            rx_busy <= 1'b0;
            bit_cnt <= '0;
            bit_num <= '0;
            shreg   <= '0;
            rx      <= '0;
        end else if (!rx_busy) begin
            if (!rxd) begin
                rx_busy <= 1'b1;
                bit_cnt <= BIT_CNT_W'(BIT_PERIOD / 2);
                bit_num <= '0;
            end
        end else if (bit_cnt != '0) begin
            bit_cnt <= bit_cnt - 1'b1;
        end else begin
            bit_cnt <= BIT_CNT_W'(BIT_PERIOD - 1);
            bit_num <= bit_num + 1'b1;
            // glitch on the start bit is not a character
            if (bit_num == '0 && rxd) begin
                rx_busy <= 1'b0;
            end else if (bit_num == STOP_POS) begin
                rx_busy  <= 1'b0;
                rx.valid <= 1'b1;
                rx.code  <= shreg[DATA_BITS-1:0];
                // [R14] parity or stop error
                rx.bad   <= (^shreg) | ~rxd;
            end else if (bit_num != '0) begin
                shreg <= {rxd, shreg[7:1]};
            end
        end
    end

    // =========================================================================
    // name match, combinational over the table
    logic       hit;
    logic [1:0] hit_idx;
    logic [5:0] total_len;

    assign total_len = {1'b0, prefix_len} + {1'b0, scan_len};

    // [R07] exact match, every character
    always_comb begin
        logic eq;
        eq      = 1'b0;
        hit     = 1'b0;
        hit_idx = '0;
        for (int n = NAME_COUNT - 1; n >= 0; n--) begin
            eq = ({1'b0, name_len[n]} == total_len) && (total_len != '0);
            for (int c = 0; c < MAX_CHARS; c++) begin
                if (6'(c) < total_len && names[n][c] != joined_char(6'(c))) begin
                    eq = 1'b0;
                end
            end
            if (eq) begin
                hit     = 1'b1;
                hit_idx = 2'(n);
            end
        end
    end

    // =========================================================================
    // register write path
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_fire;
    logic        conf_yes;
    logic        conf_no;

    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign wr_fire       = aw_have && w_have && !s_axi_bvalid;
    assign conf_yes = wr_fire && aw_addr == REG_CONFIRM && w_data[CONF_YES];
    assign conf_no  = wr_fire && aw_addr == REG_CONFIRM && w_data[CONF_NO];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= (s_axi_wstrb != '0) ? s_axi_wdata : '0;
            end
            if (wr_fire) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr <= REG_NAME_LEN && aw_addr != REG_STATUS)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_start <= 1'b0;
            mode_annot <= 1'b0;
            prefix_len <= '0;
            for (int n = 0; n < NAME_COUNT; n++) begin
                name_len[n] <= '0;
            end
        end else if (wr_fire) begin
            case (aw_addr)
                REG_CTRL: begin
                    // [R05] start mode wins, other turns off
                    mode_start <= w_data[CTRL_START];
                    mode_annot <= w_data[CTRL_ANNOT] & ~w_data[CTRL_START];
                end
                REG_PFX_LEN: begin
                    // [R09] prefix length capped at sixteen
                    prefix_len <= (w_data[4:0] > MAX_LEN) ? MAX_LEN : w_data[4:0];
                end
                REG_PFX_CHAR: prefix[w_data[IDX_LSB+:4]] <= w_data[6:0];
                REG_NAME_CHR: names[w_data[ENTRY_LSB+:2]][w_data[IDX_LSB+:4]] <= w_data[6:0];
                REG_NAME_LEN: begin
                    name_len[w_data[ENTRY_LSB+:2]] <=
                        (w_data[4:0] > MAX_LEN) ? MAX_LEN : w_data[4:0];
                end
                default: ;
            endcase
        end
    end

    // =========================================================================
    // register read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            case (s_axi_araddr)
                REG_CTRL:    s_axi_rdata <= {30'h0, mode_annot, mode_start};
                REG_STATUS:  s_axi_rdata <= {scan_count, drop_count, 3'h0, test_len,
                                             2'h0, program_index, state};
                REG_PFX_LEN: s_axi_rdata <= {27'h0, prefix_len};
                default: begin
                    // [R13] test window, four characters a word
                    if (s_axi_araddr >= REG_TEST0 && s_axi_araddr <= REG_TEST3
                        && s_axi_araddr[1:0] == 2'h0) begin
                        for (int b = 0; b < 4; b++) begin
                            s_axi_rdata[b*8+:7] <= test[{s_axi_araddr[3:2], 2'(b)}];
                        end
                    end else begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // =========================================================================
    // frame assembly and scan handling
    logic busy_ext;
    assign busy_ext = program_running | remote_download | backup_active;

    always_ff @(posedge aclk) begin
        program_load  <= 1'b0;
        program_start <= 1'b0;
        log_event     <= 1'b0;
        if (!aresetn) begin
            state         <= S_IDLE;
            scan_len      <= '0;
            frame_bad     <= 1'b0;
            drop_count    <= '0;
            scan_count    <= '0;
            test_len      <= '0;
            program_index <= '0;
            log_len       <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    // [R02] only a start character opens a frame
                    if (rx.valid && !rx.bad && rx.code == CHAR_START) begin
                        state     <= S_FRAME;
                        scan_len  <= '0;
                        frame_bad <= 1'b0;
                    end
                end
                S_FRAME: begin
                    if (rx.valid) begin
                        if (rx.bad) begin
                            frame_bad <= 1'b1;
                        end else if (rx.code == CHAR_START) begin
                            // [R14] end missing, restart on new start
                            drop_count <= drop_count + 1'b1;
                            scan_len   <= '0;
                            frame_bad  <= 1'b0;
                        end else if (rx.code == CHAR_END) begin
                            state <= S_IDLE;
                            if (frame_bad || scan_len == '0) begin
                                drop_count <= drop_count + 1'b1;
                            end else begin
                                state <= S_EVAL;
                            end
                        end else if (scan_len == MAX_LEN) begin
                            // [R04] seventeenth character spoils frame
                            frame_bad <= 1'b1;
                        end else begin
                            scan[scan_len[3:0]] <= rx.code;
                            scan_len <= scan_len + 1'b1;
                        end
                    end
                end
                S_EVAL: begin
                    state      <= S_IDLE;
                    scan_count <= scan_count + 1'b1;
                    test_len   <= scan_len;
                    // [R10] busy system ignores scan
                    if (!busy_ext) begin
                        if (mode_start && hit) begin
                            // [R06] load program, await confirm
                            program_load  <= 1'b1;
                            program_index <= hit_idx;
                            state         <= S_WAIT;
                        end else if (mode_annot) begin
                            // [R08] prefixed scan to running log
                            log_event <= 1'b1;
                            log_len   <= total_len;
                        end
                    end
                end
                S_WAIT: begin
                    // [R10] new scans ignored until answered
                    if (conf_yes) begin
                        program_start <= 1'b1;
                        state         <= S_IDLE;
                    end else if (conf_no) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // [R13] test display copy of each good scan received outside S_WAIT
    always_ff @(posedge aclk) begin
        if (state == S_EVAL) begin
            for (int c = 0; c < MAX_CHARS; c++) begin
                test[c] <= (5'(c) < scan_len) ? scan[c] : 7'h00;
            end
        end
    end

    // =========================================================================
    // backup scheduling
    // [R11] skip backup while confirm pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            backup_go   <= 1'b0;
            backup_skip <= 1'b0;
        end else begin
            backup_go   <= backup_due && state != S_WAIT;
            backup_skip <= backup_due && state == S_WAIT;
        end
    end
endmodule

/* hdl/barcode_pkg.sv */
/*
 * Constants, types and register map for the barcode frame receiver.
 * Assumes a 40 MHz system clock and 32-bit AXI4-Lite register access.
 */
package barcode_pkg;
    // =========================================================================
    // timing
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned BAUD         = 9600;
    localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD;
    localparam int unsigned BIT_CNT_W    = 16;
    // =========================================================================
    // character format and framing
    localparam int unsigned DATA_BITS    = 7;
    localparam logic [3:0]  PARITY_POS   = 4'h8;
    localparam logic [3:0]  STOP_POS     = 4'h9;
    localparam logic [6:0]  CHAR_START   = 7'h02;
    localparam logic [6:0]  CHAR_END     = 7'h03;
    localparam int unsigned MAX_CHARS    = 16;
    localparam logic [4:0]  MAX_LEN      = 5'h10;
    localparam int unsigned NAME_COUNT   = 4;
    // =========================================================================
    // register byte offsets
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_CONFIRM  = 8'h08;
    localparam logic [7:0]  REG_PFX_LEN  = 8'h0C;
    localparam logic [7:0]  REG_PFX_CHAR = 8'h10;
    localparam logic [7:0]  REG_NAME_CHR = 8'h14;
    localparam logic [7:0]  REG_NAME_LEN = 8'h18;
    localparam logic [7:0]  REG_TEST0    = 8'h20;
    localparam logic [7:0]  REG_TEST3    = 8'h2C;
    // =========================================================================
    // fields
    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned CTRL_ANNOT   = 1;
    localparam int unsigned CONF_YES     = 0;
    localparam int unsigned CONF_NO      = 1;
    localparam int unsigned IDX_LSB      = 8;
    localparam int unsigned ENTRY_LSB    = 12;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic       valid;
        logic       bad;
        logic [6:0] code;
    } rx_char_t;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_FRAME = 4'h2,
        S_EVAL  = 4'h4,
        S_WAIT  = 4'h8
    } frame_state_t;
endpackage

/* tb/barcode_monitor.sv */
/*
 * Port checker bound onto the barcode receiver.
 * Assumes one clock, sync active-low reset.
 */
`timescale 1ns/100ps
module barcode_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        program_running,
    input wire logic        remote_download,
    input wire logic        backup_active,
    input wire logic        backup_due,
    input wire logic        program_load,
    input wire logic        program_start,
    input wire logic        log_event,
    input wire logic [5:0]  log_len,
    input wire logic        backup_go,
    input wire logic        backup_skip
);
    logic busy;
    assign busy = program_running || remote_download || backup_active;
    default clocking mon_clk @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====================
    // register bus
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("aw/w ready with bvalid");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp not held");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready with rvalid");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata not held");
    // ====================
    // scan outcomes
    mode_excl_a: assert property (!(program_load && log_event))
        else $error("load with log");
    load_pulse_a: assert property (program_load |=> !program_load)
        else $error("long load");
    start_pulse_a: assert property (program_start |=> !program_start && !program_load)
        else $error("bad start");
    busy_ignore_a: assert property (busy && $past(busy) && $past(busy, 2) |-> !program_load && !log_event)
        else $error("busy scan used");
    log_length_a: assert property (log_event |-> log_len != 6'h00 && log_len <= 6'h20)
        else $error("bad log len");
    backup_answer_a: assert property (backup_due |=> backup_go ^ backup_skip)
        else $error("no backup choice");
    backup_cause_a: assert property ((backup_go || backup_skip) |-> $past(backup_due))
        else $error("backup uncaused");
endmodule

/* tb/barcode_scanner_model.sv */
/*
 * Scanner stand-in: framed 7E1 characters on rxd.
 * Assumes the bench calls its tasks; rxd idles high.
 */
`timescale 1ns/100ps
module barcode_scanner_model
    import barcode_pkg::*;
#(
    parameter int unsigned BIT_PERIOD = 16,
    parameter int unsigned GAP        = 40
) (
    input  wire logic aclk,
    output logic      rxd
);
    initial rxd = 1'b1;
    // ====================
    // characters
    // lsb first, even parity
    task automatic send_char(input logic [6:0] c, input logic bad_par);
        logic [9:0] f;
        f = {1'b1, ^c ^ bad_par, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            rxd <= f[i];
            repeat (BIT_PERIOD - 1) @(posedge aclk);
        end
    endtask
    task automatic send_frame(input logic [6:0] d [0:31], input int n, input int bad,
                              input logic close);
        send_char(CHAR_START, 1'b0);
        for (int i = 0; i < n; i++) send_char(d[i], i == bad);
        if (close) send_char(CHAR_END, 1'b0);
        repeat (GAP) @(posedge aclk);
    endtask
endmodule

/* tb/tb.sv */
/*
 * Bench for the barcode frame receiver.
 * Assumes 40 MHz clock, bit period cut to 16.
 */
`timescale 1ns/100ps
module tb;
    import barcode_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, rxd;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, backup_due = 0;
    logic        program_running = 0, remote_download = 0, backup_active = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, program_index, idx_seen;
    logic        program_load, program_start, log_event, backup_go, backup_skip;
    logic [5:0]  log_len, len_seen;
    logic [6:0]  sbuf [0:31];
    int          err_total = 0, tests_run = 0, cyc = 0;
    int          n_load = 0, n_start = 0, n_log = 0, n_go = 0, n_skip = 0;
    always #12.5 aclk = ~aclk;
    barcode_frame_receiver #(.BIT_PERIOD(16)) u_barcode_frame_receiver (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .program_running,
        .remote_download, .backup_active, .backup_due, .program_load, .program_start,
        .program_index, .log_event, .log_len, .backup_go, .backup_skip);
    barcode_scanner_model #(.BIT_PERIOD(16), .GAP(40)) u_barcode_scanner_model (
        .aclk, .rxd);
    // ====================
    // event watcher and hang guard
    always @(posedge aclk) begin
        if (program_load === 1'b1) begin n_load++; idx_seen = program_index; end
        if (log_event === 1'b1) begin n_log++; len_seen = log_len; end
        n_start += (program_start === 1'b1);
        n_go += (backup_go === 1'b1);
        n_skip += (backup_skip === 1'b1);
        if (++cyc > 60000) begin err_total++; summarize(); end
    end
    // ====================
    // compares
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin err_total++; $display("[FAIL] %s exp %0d got %0d", nm, e, g); end
    endtask
    function automatic logic [31:0] pack4(input int b, input int n);
        pack4 = 32'h0;
        for (int i = 0; i < 4; i++) if (b + i < n) pack4[8*i +: 8] = {1'b0, sbuf[b + i]};
    endfunction
    // ====================
    // bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                      input string nm);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin aw_ok = 1; s_axi_awvalid <= 0; end
            if (!w_ok && s_axi_wready === 1'b1) begin w_ok = 1; s_axi_wvalid <= 0; end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk_word(nm, {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                      input string nm);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk_word(nm, ed, s_axi_rdata);
        chk_word(nm, {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask
    task automatic scan(input int n, input int bad, input logic close);
        u_barcode_scanner_model.send_frame(sbuf, n, bad, close);
        repeat (40) @(posedge aclk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ====================
    // main sequence
    initial begin
        void'($urandom(32'h70E4));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_CTRL, 32'h0, RESP_OKAY, "ctrl reset");
        rd(REG_STATUS, 32'h1, RESP_OKAY, "status reset");
        rd(8'h40, 32'h0, RESP_SLVERR, "unmapped read");
        wr(REG_STATUS, 32'h0, RESP_SLVERR, "status write");
        wr(REG_CTRL, 32'h3, RESP_OKAY, "ctrl both");
        rd(REG_CTRL, 32'h1, RESP_OKAY, "ctrl start only");
        wr(REG_CTRL, 32'h2, RESP_OKAY, "ctrl annot");
        rd(REG_CTRL, 32'h2, RESP_OKAY, "ctrl annot only");
        $display("test registers done");
        sbuf[0] = 7'h41;
        sbuf[1] = 7'h42;
        scan(2, -1, 1);
        chk_cnt("log count", 1, n_log);
        chk_word("log len", 32'h2, {26'h0, len_seen});
        rd(REG_TEST0, pack4(0, 2), RESP_OKAY, "test window");
        for (int i = 0; i < 17; i++) sbuf[i] = 7'h20 + 7'($urandom % 95);
        scan(16, -1, 1);
        chk_word("len sixteen", 32'h10, {26'h0, len_seen});
        rd(REG_TEST3, pack4(12, 16), RESP_OKAY, "test tail");
        scan(17, -1, 1);
        scan(2, 1, 1);
        scan(2, -1, 0);
        chk_cnt("drops", 2, n_log);
        sbuf[0] = 7'h42;
        scan(1, -1, 1);
        chk_word("reopen", 32'h1, {26'h0, len_seen});
        wr(REG_PFX_LEN, 32'h1, RESP_OKAY, "prefix len");
        wr(REG_PFX_CHAR, 32'h50, RESP_OKAY, "prefix char");
        {sbuf[0], sbuf[1]} = {7'h41, 7'h42};
        scan(2, -1, 1);
        chk_word("prefixed len", 32'h3, {26'h0, len_seen});
        $display("test annotation done");
        wr(REG_CTRL, 32'h1, RESP_OKAY, "ctrl start");
        for (int e = 0; e < 2; e++) begin
            wr(REG_NAME_LEN, (e << 12) | 3, RESP_OKAY, "name len");
            wr(REG_NAME_CHR, (e << 12) | 32'h050, RESP_OKAY, "name p");
            wr(REG_NAME_CHR, (e << 12) | 32'h141, RESP_OKAY, "name a");
            wr(REG_NAME_CHR, (e << 12) | (e ? 32'h242 : 32'h258), RESP_OKAY, "name c");
        end
        sbuf[1] = 7'h43;
        scan(2, -1, 1);
        chk_cnt("unmatched", 0, n_load);
        sbuf[1] = 7'h42;
        scan(2, -1, 1);
        chk_cnt("load count", 1, n_load);
        chk_word("load index", 32'h1, {30'h0, idx_seen});
        chk_cnt("log in start mode", 4, n_log);
        @(posedge aclk) backup_due <= 1'b1;
        @(posedge aclk) backup_due <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_cnt("skip", 1, n_skip);
        wr(REG_CONFIRM, 32'h1, RESP_OKAY, "confirm");
        repeat (4) @(posedge aclk);
        chk_cnt("start count", 1, n_start);
        @(posedge aclk) backup_due <= 1'b1;
        @(posedge aclk) backup_due <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_cnt("go", 1, n_go);
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk) {backup_active, remote_download, program_running} <= 3'(1 << k);
            scan(2, -1, 1);
            @(posedge aclk) {backup_active, remote_download, program_running} <= 3'h0;
        end
        chk_cnt("busy", 1, n_load);
        $display("test program start done");
        summarize();
    end
endmodule
bind barcode_frame_receiver barcode_monitor u_barcode_monitor (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .program_running, .remote_download, .backup_active, .backup_due, .program_load,
    .program_start, .log_event, .log_len, .backup_go, .backup_skip);
